// >>> rtl/sar_adc_ctrl.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module sar_adc_ctrl
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Analog front end
    input wire logic cmp_in,
    input wire logic osc_clk_in,
    output logic [7:0] dac_code,
    output logic [2:0] analog_sel,
    output logic [1:0] mux_src,
    output logic power_off,
    // Shared port pins
    input wire logic [7:0] port_rd_raw,
    output logic [7:0] port_rd_data,
    output logic [7:0] pin_force_input,
    // Low power and request
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic irq,
    output logic wake_req
);
    conv_if cv ();

    bus_state_t bus_q;
    logic [9:0] addr_q;
    logic wr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic flag_q;
    logic irqen_q;
    logic cont_q;
    logic [4:0] ch_q;
    logic [2:0] div_q;
    logic src_q;
    logic [7:0] result_q;
    logic first_q;
    logic pend_q;
    logic stop_prev_q;
    logic irq_q;
    logic wake_q;
    logic cmp_s1_q;
    logic cmp_s2_q;
    logic [2:0] sel_q;
    mux_src_t mux_q;
    logic off_q;
    logic [7:0] force_q;
    logic [7:0] port_q;
    logic take;
    logic acc;
    logic sc_wr;
    logic res_rd;
    logic clk_wr;
    logic [4:0] ch_new;
    logic hw_set;
    logic resume;
    logic [7:0] sc_view;

    // Address match against a register index
    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        return a == `REG_ADDR(idx);
    endfunction

    // One-hot pin mask for a channel code, empty outside the pin range
    function automatic logic [7:0] pin_mask(input logic [4:0] ch);
        if (ch > `CH_LAST_PIN)
            return 8'h00;
        return 8'h01 << ch[2:0];
    endfunction

    adc_clk_gen u_clk (
        .hclk(hclk),
        .hresetn(hresetn),
        .osc_clk_in(osc_clk_in),
        .src_bus(src_q),
        .div_sel(div_q),
        .cv(cv.gen)
    );

    sar_engine u_eng (
        .hclk(hclk),
        .hresetn(hresetn),
        .cv(cv.eng)
    );

    // Bus decode; every transfer takes one wait state so reads see prior writes
    assign take = hsel && hready && htrans[1];
    assign acc = (bus_q == BUS_WAIT);
    assign sc_wr = acc && wr_q && hit(addr_q, `SC_IDX);
    assign clk_wr = acc && wr_q && hit(addr_q, `CLK_IDX);
    assign res_rd = acc && !wr_q && hit(addr_q, `RES_IDX);
    assign ch_new = hwdata[`SC_CH_MSB:0];
    assign sc_view = {flag_q, irqen_q, cont_q, ch_q};

    // Bus phase sequencing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_q <= BUS_IDLE;
            addr_q <= 10'h000;
            wr_q <= 1'b0;
            hreadyout_q <= 1'b1;
        end
        else
        begin
            case (bus_q)
                BUS_IDLE, BUS_DONE:
                begin
                    hreadyout_q <= !take;
                    bus_q <= take ? BUS_WAIT : BUS_IDLE;
                    if (take)
                    begin
                        addr_q <= haddr[9:0];
                        wr_q <= hwrite;
                    end
                end
                BUS_WAIT:
                begin
                    bus_q <= BUS_DONE;
                    hreadyout_q <= 1'b1;
                end
                default:
                begin
                    bus_q <= BUS_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    // Read data; unmapped addresses return zero, writes leave the last read value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (acc && !wr_q)
        begin
            if (hit(addr_q, `SC_IDX))
                hrdata_q <= {24'h000000, sc_view};
            else if (hit(addr_q, `RES_IDX))
                hrdata_q <= {24'h000000, result_q};
            else if (hit(addr_q, `CLK_IDX))
                hrdata_q <= {24'h000000, div_q, src_q, 4'h0};
            else
                hrdata_q <= 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irqen_q <= 1'b0;
            cont_q <= 1'b0;
            ch_q <= `CH_OFF;
        end
        else if (sc_wr)
        begin
            irqen_q <= hwdata[`SC_IRQEN];
            cont_q <= hwdata[`SC_CONT];
            ch_q <= ch_new;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 3'(`CK_RESET >> `CK_DIV_LSB);
            src_q <= 1'b0;
        end
        else if (clk_wr)
        begin
            div_q <= hwdata[`CK_DIV_MSB:`CK_DIV_LSB];
            src_q <= hwdata[`CK_SRC];
        end
    end

    // Comparator is analog; the first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            cmp_s1_q <= cmp_in;
            cmp_s2_q <= cmp_s1_q;
        end
    end
    assign cv.cmp = cmp_s2_q;

    // a conversion cut short by stop mode is restarted on exit
    assign resume = stop_prev_q && !stop_mode && pend_q && ch_q != `CH_OFF;

    // a write restarts sequencing; one start per write
    // continuous mode chains the next start onto each completion
    assign cv.start = !stop_mode && ((sc_wr && ch_new != `CH_OFF) || resume
        || (cv.done && cont_q && !sc_wr && ch_q != `CH_OFF));
    // power-off code also stops the sequencer
    assign cv.abort = sc_wr || stop_mode || ch_q == `CH_OFF;

    // Outstanding work, used to resume after stop mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_q <= 1'b0;
            stop_prev_q <= 1'b0;
        end
        else
        begin
            stop_prev_q <= stop_mode;
            if (sc_wr)
                pend_q <= ch_new != `CH_OFF;
            else if (cv.done && !cont_q)
                pend_q <= 1'b0;
        end
    end

    // result register, overwritten whether read or not
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            result_q <= 8'h00;
        else if (cv.done)
            result_q <= cv.result;
    end

    // only the first completion after a write may set the flag
    assign hw_set = cv.done && !irqen_q && !(cont_q && first_q);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            first_q <= 1'b0;
        else if (sc_wr)
            first_q <= 1'b0;
        else if (cv.done)
            first_q <= 1'b1;
    end

    // set beats clear; flag is plain storage with interrupts on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_q <= 1'b0;
        else if (hw_set)
            flag_q <= 1'b1;
        else if (sc_wr)
            flag_q <= irqen_q ? hwdata[`SC_FLAG] : 1'b0;
        else if (res_rd && !irqen_q)
            flag_q <= 1'b0;
    end

    // request on every completion with interrupts enabled, set beats withdrawal
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_q <= 1'b0;
        else if (cv.done && irqen_q)
            irq_q <= 1'b1;
        else if (sc_wr || res_rd)
            irq_q <= 1'b0;
    end

    // a pending request during wait mode wakes the processor
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_q <= 1'b0;
        else
            wake_q <= wait_mode && irq_q;
    end

    // mux routing; reserved codes connect nothing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_q <= 3'h0;
            mux_q <= MUX_NONE;
            off_q <= 1'b1;
        end
        else
        begin
            sel_q <= ch_q[2:0];
            off_q <= ch_q == `CH_OFF || stop_mode;
            if (ch_q <= `CH_LAST_PIN)
                mux_q <= MUX_PIN;
            else if (ch_q == `CH_REFH)
                mux_q <= MUX_REFH;
            else if (ch_q == `CH_REFL)
                mux_q <= MUX_REFL;
            else
                mux_q <= MUX_NONE;
        end
    end

    // claim the selected pin and hide it from port reads
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            force_q <= 8'h00;
            port_q <= 8'h00;
        end
        else
        begin
            force_q <= pin_mask(ch_q);
            port_q <= port_rd_raw & ~pin_mask(ch_q);
        end
    end

    // Output drive, all from flops except hresp, tied low
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign dac_code = cv.trial;
    assign analog_sel = sel_q;
    assign mux_src = mux_q;
    assign power_off = off_q;
    assign port_rd_data = port_q;
    assign pin_force_input = force_q;
    assign irq = irq_q;
    assign wake_req = wake_q;

    // Checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_cont_done;
        cv.done && cont_q && !sc_wr && !stop_mode && ch_q != `CH_OFF;
    endsequence
    sequence s_single_done;
        cv.done && !cont_q && !sc_wr;
    endsequence

    AST_OVERWRITE: assert property (cv.done |=> result_q == $past(cv.result))
        else $error("result not updated at conversion end");
    AST_CONT_CHAIN: assert property (s_cont_done |=> cv.busy)
        else $error("continuous mode did not restart");
    AST_FLAG_ONCE: assert property (cv.done && cont_q && first_q && !irqen_q
        && !sc_wr && !res_rd |=> flag_q == $past(flag_q))
        else $error("flag changed after first continuous conversion");
    AST_SINGLE_ONE: assert property (s_single_done ##1 !sc_wr[*2] |-> !cv.busy)
        else $error("single mode started a second conversion");
    AST_FLAG_SET: assert property (hw_set |=> flag_q)
        else $error("flag not set at conversion end");
    AST_IRQ_SET: assert property (cv.done && irqen_q |=> irq_q)
        else $error("request missing at conversion end");
    AST_IRQ_CLR: assert property ((sc_wr || res_rd) && !cv.done |=> !irq_q)
        else $error("request not withdrawn");
    AST_RESET_VAL: assert property ($rose(hresetn) |-> sc_view == `SC_RESET
        && !src_q)
        else $error("wrong values after reset");
    AST_STOP_ABORT: assert property (stop_mode |=> !cv.busy && power_off)
        else $error("converter active in stop mode");
    AST_WRITE_RESTART: assert property (sc_wr && ch_new != `CH_OFF && !stop_mode
        |=> cv.busy && ch_q == $past(ch_new))
        else $error("write did not restart sequencing");
    AST_PIN_OWN: assert property (##1 pin_force_input == pin_mask($past(ch_q)))
        else $error("pin ownership mask wrong");
    AST_OFF_CODE: assert property (ch_q == `CH_OFF |=> power_off)
        else $error("power-off code left converter on");
endmodule

// >>> rtl/adc_ctrl_defines.svh
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
// Register indices; byte address is four times the index
`define SC_IDX 8'h38
`define RES_IDX 8'h39
`define CLK_IDX 8'h3A
`define REG_ADDR(i) {(i), 2'b00}
// Status/control fields
`define SC_FLAG 7
`define SC_IRQEN 6
`define SC_CONT 5
`define SC_CH_MSB 4
`define SC_RESET 8'h1F
// Clock config fields
`define CK_DIV_MSB 7
`define CK_DIV_LSB 5
`define CK_SRC 4
`define CK_RESET 8'h00
`define CK_DIV16_BIT 2
// Channel codes
`define CH_LAST_PIN 5'h07
`define CH_REFH 5'h1D
`define CH_REFL 5'h1E
`define CH_OFF 5'h1F
// Converter sequencing
`define SAR_MSB 3'h7
`define SAR_DONE_IDX 5'h10
`define SAR_TICKS 5'h11
`endif

// >>> rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;
    typedef enum logic [1:0] {
        MUX_PIN = 2'b00,
        MUX_REFH = 2'b01,
        MUX_REFL = 2'b10,
        MUX_NONE = 2'b11
    } mux_src_t;
    typedef enum logic {
        ENG_IDLE = 1'b0,
        ENG_RUN = 1'b1
    } eng_state_t;
endpackage

// >>> rtl/conv_if.sv
`timescale 1ns/1ps
// Converter clock, sequencer and control plane
interface conv_if;
    logic adc_tick;
    logic start;
    logic abort;
    logic cmp;
    logic busy;
    logic done;
    logic [7:0] trial;
    logic [7:0] result;
    modport gen (output adc_tick);
    modport eng (input adc_tick, input start, input abort, input cmp,
        output busy, output done, output trial, output result);
    modport ctl (input adc_tick, input busy, input done, input trial,
        input result, output start, output abort, output cmp);
endinterface

// >>> rtl/adc_clk_gen.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_clk_gen
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Source and ratio
    input wire logic osc_clk_in,
    input wire logic src_bus,
    input wire logic [2:0] div_sel,
    // Converter clock out
    conv_if.gen cv
);
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic [3:0] cnt_q;
    logic tick_q;
    logic src_tick;

    // Terminal count: ratios 1, 2, 4, 8, and 16 for any top-bit code
    function automatic logic [3:0] div_limit(input logic [2:0] d);
        if (d[`CK_DIV16_BIT])
            return 4'hF;
        return 4'((5'h01 << d[1:0]) - 5'h01);
    endfunction

    // Oscillator is asynchronous; only the second and third stages feed the edge detect
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= osc_clk_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign src_tick = src_bus | (osc_s2_q & ~osc_s3_q);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 4'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (src_tick)
            begin
                if (cnt_q >= div_limit(div_sel))
                begin
                    cnt_q <= 4'h0;
                    tick_q <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign cv.adc_tick = tick_q;
endmodule

// >>> rtl/sar_engine.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module sar_engine
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control plane
    conv_if.eng cv
);
    eng_state_t state_q;
    logic [4:0] idx_q;
    logic [7:0] trial_q;
    logic done_q;
    logic [4:0] ticks_q;

    // Bit under trial for a given step
    function automatic logic [2:0] bit_of(input logic [4:0] i);
        return 3'(`SAR_MSB - i[3:1]);
    endfunction

    // even steps raise a trial bit, odd steps keep or drop it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ENG_IDLE;
            idx_q <= 5'h00;
            trial_q <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (cv.start)
            begin
                state_q <= ENG_RUN;
                idx_q <= 5'h00;
                trial_q <= 8'h00;
            end
            else if (cv.abort)
                state_q <= ENG_IDLE;
            else if (state_q == ENG_RUN && cv.adc_tick)
            begin
                idx_q <= idx_q + 5'h01;
                if (idx_q == `SAR_DONE_IDX)
                begin
                    state_q <= ENG_IDLE;
                    done_q <= 1'b1;
                end
                else if (!idx_q[0])
                    trial_q[bit_of(idx_q)] <= 1'b1;
                else if (!cv.cmp)
                    trial_q[bit_of(idx_q)] <= 1'b0;
            end
        end
    end

    assign cv.busy = (state_q == ENG_RUN);
    assign cv.done = done_q;
    assign cv.trial = trial_q;
    assign cv.result = trial_q;

    // Tick count since start, read only by the check below
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ticks_q <= 5'h00;
        else if (cv.start)
            ticks_q <= 5'h00;
        else if (state_q == ENG_RUN && cv.adc_tick)
            ticks_q <= ticks_q + 5'h01;
    end

    AST_CONV_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
        done_q |-> ticks_q == `SAR_TICKS)
        else $error("conversion did not take seventeen converter ticks");
endmodule

// >>> verification/analog_src.sv
`timescale 1ns/1ps
module analog_src
    import adc_ctrl_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Converter side
    input wire logic [7:0] dac_code,
    input wire logic [2:0] analog_sel,
    input wire logic [1:0] mux_src,
    input wire logic [63:0] pin_levels,
    output logic cmp_in
);
    logic noise_q = 1'b0;
    logic [7:0] lvl;

    // Reserved or off codes have no defined input, so the line keeps changing
    always @(posedge hclk)
        noise_q <= ~noise_q;

    assign lvl = pin_levels[{analog_sel, 3'b000} +: 8];

    // Comparator high while the source sits at or above the trial code
    always_comb
    begin
        case (mux_src)
            MUX_PIN: cmp_in = (lvl >= dac_code);
            MUX_REFH: cmp_in = 1'b1;
            MUX_REFL: cmp_in = (dac_code == 8'h00);
            default: cmp_in = noise_q;
        endcase
    end
endmodule

// >>> verification/sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module sar_adc_conversion_control_tb;
    import adc_ctrl_pkg::*;
    localparam logic [31:0] A_SC = {22'h0, `REG_ADDR(`SC_IDX)};
    localparam logic [31:0] A_RS = {22'h0, `REG_ADDR(`RES_IDX)};
    localparam logic [31:0] A_CK = {22'h0, `REG_ADDR(`CLK_IDX)};
    localparam int TMO = 20000;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rdat_n;
    logic [1:0] htrans = 2'h0, mux_src;
    logic [2:0] hsize = 3'h2, analog_sel;
    logic hreadyout, hresp, cmp_in, power_off, irq, wake_req, rdy_n;
    logic osc_clk_in = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0;
    logic [7:0] dac_code, port_rd_data, pin_force_input, port_rd_raw = 8'hFF;
    logic [63:0] lvls = 64'h01E13CA57EC4135A;
    logic [7:0] ck_tab [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
    int per_tab [7] = '{1, 2, 4, 8, 16, 16, 14};
    logic [4:0] ch_tab [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 5'h1D, 5'h1E, 5'h08, 5'h1C};
    int cyc = 0, n_mismatch = 0, cmp_count = 0, n;
    logic [7:0] ex;

    sar_adc_ctrl sar_adc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp_in(cmp_in),
        .osc_clk_in(osc_clk_in), .dac_code(dac_code), .analog_sel(analog_sel),
        .mux_src(mux_src), .power_off(power_off), .port_rd_raw(port_rd_raw),
        .port_rd_data(port_rd_data), .pin_force_input(pin_force_input),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .irq(irq), .wake_req(wake_req));

    analog_src analog_src_inst (.hclk(hclk), .dac_code(dac_code), .analog_sel(analog_sel),
        .mux_src(mux_src), .pin_levels(lvls), .cmp_in(cmp_in));

    always #5 hclk = ~hclk;

    // Bus answers sampled half a cycle early; nothing moves between here and the edge
    always @(negedge hclk)
    begin
        rdy_n = hreadyout;
        rdat_n = hrdata;
    end

    // Oscillator at 1/14 of the bus clock, plus the hang guard
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc % 7 == 0)
            osc_clk_in <= ~osc_clk_in;
        if (cyc == TMO)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single AHB transfer; held until hready is seen high at an edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (rdy_n !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (rdy_n !== 1'b1)
            @(posedge hclk);
        rd = rdat_n;
    endtask

    // Poll the done flag; n returns elapsed bus cycles
    task automatic poll();
        int t0;
        t0 = cyc;
        for (int i = 0; i < 400; i++)
        begin
            bus(1'b0, A_SC, 8'h00);
            if (rd[7] === 1'b1)
                break;
        end
        n = cyc - t0;
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 600 && irq !== 1'b1; i++)
            @(posedge hclk);
    endtask

    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, A_SC, 8'h00); chk(rd, 32'h1F);
        bus(1'b0, A_CK, 8'h00); chk(rd, 32'h00);
        bus(1'b0, A_RS, 8'h00); chk(rd, 32'h00);
        chk(32'(power_off), 32'h1);
        bus(1'b0, A_SC + 32'hC, 8'h00); chk(rd, 32'h0);
        chk(32'(hresp), 32'h0);
        bus(1'b1, A_RS, 8'h55); bus(1'b0, A_RS, 8'h00); chk(rd, 32'h00);
        bus(1'b1, A_CK, 8'h9F); bus(1'b0, A_CK, 8'h00); chk(rd, 32'h90);
        $display("test reset done");
        // Each source and divider: time from write to flag, one conversion per write
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, A_CK, ck_tab[k]);
            bus(1'b1, A_SC, 8'h00);
            poll(); chk(32'(rd[7]), 32'h1);
            chk(32'(n >= 16 * per_tab[k] && n <= 17 * per_tab[k] + 10), 32'h1);
            bus(1'b0, A_RS, 8'h00);
            if (per_tab[k] >= 4)
                chk(rd, {24'h0, lvls[7:0]});
            bus(1'b0, A_SC, 8'h00); chk(32'(rd[7]), 32'h0);
        end
        $display("test clock done");
        bus(1'b1, A_CK, 8'h90);
        // Pin, reference and two reserved codes: pin steering, mux source, result for all but the reserved
        for (int k = 0; k < 12; k++)
        begin
            bus(1'b1, A_SC, {3'b000, ch_tab[k]});
            ex = (ch_tab[k] < 5'h08) ? 8'h01 << ch_tab[k][2:0] : 8'h00;
            // Steering flops load at the edge the write ends on; look once they settle
            @(negedge hclk);
            chk(32'(pin_force_input), 32'(ex));
            chk(32'(port_rd_data), 32'(port_rd_raw & ~ex));
            chk(32'(analog_sel), 32'(ch_tab[k][2:0]));
            chk(32'(mux_src), (k < 8) ? 32'h0 : (k == 8) ? 32'h1 : (k == 9) ? 32'h2 : 32'h3);
            @(posedge hclk);
            poll(); chk(32'(rd[7]), 32'h1);
            bus(1'b0, A_RS, 8'h00);
            ex = (k < 8) ? lvls[8 * k +: 8] : (k == 8) ? 8'hFF : 8'h00;
            if (k < 10)
            begin
                chk(rd, 32'(ex));
                chk(32'(dac_code), 32'(ex));
            end
        end
        repeat (600) @(posedge hclk);
        bus(1'b0, A_SC, 8'h00); chk(32'(rd[7]), 32'h0);
        $display("test channels done");
        bus(1'b1, A_SC, 8'h1F);
        @(negedge hclk);
        chk(32'(power_off), 32'h1);
        repeat (600) @(posedge hclk);
        bus(1'b0, A_SC, 8'h00); chk(rd, 32'h1F);
        // Restart with a different channel in mid-conversion
        bus(1'b1, A_SC, 8'h01);
        repeat (100) @(posedge hclk);
        bus(1'b1, A_SC, 8'h06);
        poll(); bus(1'b0, A_RS, 8'h00); chk(rd, {24'h0, lvls[55:48]});
        $display("test abort done");
        bus(1'b1, A_SC, 8'h22);
        poll(); bus(1'b0, A_RS, 8'h00); chk(rd, {24'h0, lvls[23:16]});
        lvls[23:16] <= 8'h6B;
        repeat (700) @(posedge hclk);
        bus(1'b0, A_SC, 8'h00); chk(32'(rd[7]), 32'h0);
        bus(1'b0, A_RS, 8'h00); chk(rd, 32'h6B);
        lvls[23:16] <= 8'h2D;
        repeat (700) @(posedge hclk);
        bus(1'b0, A_RS, 8'h00); chk(rd, 32'h2D);
        $display("test continuous done");
        wait_mode <= 1'b1;
        bus(1'b1, A_SC, 8'h44);
        wait_irq(); chk(32'(irq), 32'h1);
        repeat (2) @(posedge hclk);
        chk(32'(wake_req), 32'h1);
        bus(1'b0, A_RS, 8'h00); chk(rd, {24'h0, lvls[39:32]});
        chk(32'(irq), 32'h0);
        bus(1'b1, A_SC, 8'hC4); bus(1'b0, A_SC, 8'h00); chk(rd, 32'hC4);
        bus(1'b1, A_SC, 8'h44); bus(1'b0, A_SC, 8'h00); chk(rd, 32'h44);
        wait_irq(); bus(1'b1, A_SC, 8'h04); chk(32'(irq), 32'h0);
        wait_mode <= 1'b0;
        $display("test interrupt done");
        bus(1'b1, A_SC, 8'h03);
        repeat (50) @(posedge hclk);
        stop_mode <= 1'b1;
        repeat (600) @(posedge hclk);
        chk(32'(power_off), 32'h1);
        bus(1'b0, A_SC, 8'h00); chk(32'(rd[7]), 32'h0);
        stop_mode <= 1'b0;
        poll(); chk(32'(rd[7]), 32'h1);
        // First value after stop is only settling, so it is read and dropped
        bus(1'b0, A_RS, 8'h00);
        $display("test stop done");
        end_of_test();
    end
endmodule
